// ---- hw/gpic_pkg.sv ----
package gpic_pkg;
  // ==================================================
  // Register addresses (8-bit special-function space)
  localparam logic [7:0] ADDR_PIN_ROUTE   = 8'hA6;
  localparam logic [7:0] ADDR_ENABLE_1ST  = 8'hA8;
  localparam logic [7:0] ADDR_PRIO_LOW    = 8'hA9;
  localparam logic [7:0] ADDR_ENABLE_2ND  = 8'hB8;
  localparam logic [7:0] ADDR_PRIO_HIGH   = 8'hB9;
  localparam logic [7:0] ADDR_REQ_FLAGS   = 8'hC0;
  // ==================================================
  // Reset values
  localparam logic [7:0] RST_PIN_ROUTE    = 8'h01;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  // ==================================================
  // Field positions, first enable bank
  localparam int EN0_GLOBAL   = 7;
  localparam int EN0_TIMER2   = 5;
  localparam int EN0_SERIAL   = 4;
  localparam int EN0_TIMER1   = 3;
  localparam int EN0_POWER    = 2;
  localparam int EN0_TIMER0   = 1;
  localparam int EN0_PIN      = 0;
  // Second enable bank
  localparam int EN1_RELOAD   = 7;
  localparam int EN1_TICK     = 5;
  localparam int EN1_MISC     = 4;
  localparam int EN1_WAKEPIN  = 3;
  localparam int EN1_SERDONE  = 2;
  localparam int EN1_RFEVENT  = 1;
  localparam int EN1_RFREADY  = 0;
  // Pin-route register
  localparam int PR_GPIN2     = 5;
  localparam int PR_GPIN1     = 4;
  localparam int PR_GPIN0     = 3;
  localparam int PR_TWOWIRE   = 2;
  localparam int PR_SPIM      = 1;
  localparam int PR_SPIS      = 0;
  // Request flag register positions
  localparam int RF_RELOAD    = 7;
  localparam int RF_T2OVF     = 6;
  localparam int RF_TICK      = 5;
  localparam int RF_MISC      = 4;
  localparam int RF_WAKEPIN   = 3;
  localparam int RF_SERDONE   = 2;
  localparam int RF_RFEVENT   = 1;
  localparam int RF_RFREADY   = 0;
  localparam logic [7:0] RF_AUTO_CLEAR = 8'h3E;
  localparam logic [7:0] PRIO_USED     = 8'h3F;
  localparam logic [7:0] EN0_USED      = 8'hBF;
  localparam logic [7:0] EN1_USED      = 8'hBF;
  localparam logic [7:0] PR_USED       = 8'h3F;
  // ==================================================
  // Interrupt lines, ordered by vector address
  localparam int NUM_LINES = 12;
  localparam int NUM_GROUPS = 6;
  typedef logic [15:0] gpic_vec_t;
  typedef logic [1:0]  gpic_level_t;
  typedef logic [3:0]  gpic_line_t;
  localparam gpic_vec_t VECTORS [NUM_LINES] = '{
    16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
    16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B};
  // Priority group of each line
  localparam int GROUP_OF [NUM_LINES] = '{0, 1, 2, 3, 4, 5, 0, 1, 2, 3, 4, 5};
endpackage : gpic_pkg

// ---- hw/gpic_arb_if.sv ----
interface gpic_arb_if;
  import gpic_pkg::*;
  logic [NUM_LINES-1:0] pending;
  gpic_level_t          level [NUM_LINES];
  logic [3:0]           active_levels;
  logic                 found;
  gpic_line_t           line;
  gpic_level_t          line_level;
  modport ctrl (output pending, level, active_levels, input found, line, line_level);
  modport arb  (input pending, level, active_levels, output found, line, line_level);
endinterface : gpic_arb_if

// ---- hw/gpic_arbiter.sv ----
module gpic_arbiter
  import gpic_pkg::*;
(
  gpic_arb_if.arb bus
);
  // ==================================================
  // Highest level first, lowest vector among equals; must exceed running levels
  logic [NUM_LINES-1:0] elig;
  logic [3:0]           running_top_mask;
  always_comb begin
    // Levels strictly above the highest running one may preempt
    running_top_mask = 4'hF;
    for (int l = 0; l < 4; l++) begin
      if (bus.active_levels[l]) begin
        running_top_mask = 4'hF << (l + 1);
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_elig
      assign elig[g] = bus.pending[g] && running_top_mask[bus.level[g]];
    end
  endgenerate
  always_comb begin
    bus.found      = 1'b0;
    bus.line       = '0;
    bus.line_level = '0;
    for (int l = 0; l < 4; l++) begin
      for (int i = NUM_LINES - 1; i >= 0; i--) begin
        if (elig[i] && bus.level[i] == l[1:0]) begin
          bus.found      = 1'b1;
          bus.line       = i[3:0];
          bus.line_level = l[1:0];
        end
      end
    end
  end
endmodule : gpic_arbiter

// ---- hw/gpic_controller.sv ----
module gpic_controller
  import gpic_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [2:0] general_pin_input,
  input  wire logic       timer0_overflow_req,
  input  wire logic       timer1_overflow_req,
  input  wire logic       timer2_overflow_req,
  input  wire logic       timer2_reload_req,
  input  wire logic       serial_receive_req,
  input  wire logic       serial_transmit_req,
  input  wire logic       power_failure_req,
  input  wire logic       radio_port_ready_req,
  input  wire logic       radio_event_req,
  input  wire logic       spi_master_done_req,
  input  wire logic       spi_slave_done_req,
  input  wire logic       two_wire_done_req,
  input  wire logic       wake_on_pin_req,
  input  wire logic       crystal_started_event,
  input  wire logic       converter_ready_event,
  input  wire logic       random_ready_event,
  input  wire logic       tick_req,
  input  wire logic [3:0] wakeup_enable,
  output logic            irq_request,
  output logic     [15:0] irq_vector,
  output logic      [1:0] irq_level,
  input  wire logic       irq_ack,
  input  wire logic       irq_return,
  output logic      [3:0] irq_active_levels
);
  import gpic_pkg::*;

  // ==================================================
  // Registers
  logic [7:0] pin_route_and_serial_done_enable_reg;
  logic [7:0] irq_enable_first_bank_reg;
  logic [7:0] irq_enable_second_bank_reg;
  logic [7:0] irq_priority_low_bits_reg;
  logic [7:0] irq_priority_high_bits_reg;
  logic [7:0] request_flag_reg;
  logic [7:0] request_flag_next;
  logic [3:0] active_reg;
  logic [3:0] active_next;
  logic [15:0] vector_reg;
  logic [1:0]  level_reg;
  logic [11:0] prev_in_reg;

  // ==================================================
  // Register write decode
  // One decode shared by every write enable
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    return wr && addr == target;
  endfunction
  logic we_pin_route;
  logic we_enable_1st;
  logic we_enable_2nd;
  logic we_prio_low;
  logic we_prio_high;
  assign we_pin_route  = wr_hit(reg_wr, reg_addr, ADDR_PIN_ROUTE);
  assign we_enable_1st = wr_hit(reg_wr, reg_addr, ADDR_ENABLE_1ST);
  assign we_enable_2nd = wr_hit(reg_wr, reg_addr, ADDR_ENABLE_2ND);
  assign we_prio_low   = wr_hit(reg_wr, reg_addr, ADDR_PRIO_LOW);
  assign we_prio_high  = wr_hit(reg_wr, reg_addr, ADDR_PRIO_HIGH);

  // ==================================================
  // Edge detection on edge-type sources
  // Previous levels reset low, the idle level of every edge source
  logic [11:0] raw_in;
  logic        pin_active;
  logic        misc_or;
  // No routed pin means no request, whatever the pin levels
  assign pin_active = |(~general_pin_input &
    {pin_route_and_serial_done_enable_reg[PR_GPIN2],
     pin_route_and_serial_done_enable_reg[PR_GPIN1],
     pin_route_and_serial_done_enable_reg[PR_GPIN0]});
  assign misc_or = crystal_started_event | converter_ready_event | random_ready_event;
  assign raw_in = {tick_req, misc_or, wake_on_pin_req, two_wire_done_req,
                   spi_master_done_req, spi_slave_done_req, radio_event_req,
                   5'h00};
  logic [11:0] toggled;
  logic [11:0] rising;
  assign toggled = raw_in ^ prev_in_reg;
  assign rising  = raw_in & ~prev_in_reg;
  logic ev_tick;
  logic ev_misc;
  logic ev_wake;
  logic ev_serdone;
  logic ev_rfevent;
  assign ev_tick    = rising[11] & wakeup_enable[3];
  assign ev_misc    = rising[10] & wakeup_enable[2];
  assign ev_wake    = rising[9] & wakeup_enable[1];
  assign ev_serdone = (toggled[8] & pin_route_and_serial_done_enable_reg[PR_TWOWIRE]) |
                      (toggled[7] & pin_route_and_serial_done_enable_reg[PR_SPIM]) |
                      (toggled[6] & pin_route_and_serial_done_enable_reg[PR_SPIS]);
  assign ev_rfevent = toggled[5] & wakeup_enable[0];

  // ==================================================
  // Request flags; hardware set wins over clears
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic       flag_wr;
  assign flag_wr  = wr_hit(reg_wr, reg_addr, ADDR_REQ_FLAGS);
  assign flag_set = {timer2_reload_req, timer2_overflow_req, ev_tick, ev_misc,
                     ev_wake, ev_serdone, ev_rfevent, radio_port_ready_req};
  logic [7:0] svc_clr;
  assign flag_clr = svc_clr & RF_AUTO_CLEAR;
  always_comb begin
    request_flag_next = request_flag_reg & ~flag_clr;
    if (flag_wr) begin
      request_flag_next = reg_wdata;
    end
    request_flag_next = request_flag_next | flag_set;
  end

  // ==================================================
  // Per-line pending, levels and arbitration
  gpic_arb_if arb_bus ();
  logic [NUM_LINES-1:0] line_req;
  logic [NUM_LINES-1:0] line_en;
  logic                 global_en;
  // Global enable masks the offer only; flags keep collecting
  assign global_en = irq_enable_first_bank_reg[EN0_GLOBAL];
  assign line_req = {request_flag_reg[RF_TICK], request_flag_reg[RF_MISC],
                     request_flag_reg[RF_WAKEPIN], request_flag_reg[RF_SERDONE],
                     request_flag_reg[RF_RFEVENT], request_flag_reg[RF_RFREADY],
                     request_flag_reg[RF_T2OVF] | request_flag_reg[RF_RELOAD],
                     serial_receive_req | serial_transmit_req,
                     timer1_overflow_req,
                     ~power_failure_req,
                     timer0_overflow_req,
                     pin_active};
  assign line_en = {irq_enable_second_bank_reg[EN1_TICK],
                    irq_enable_second_bank_reg[EN1_MISC],
                    irq_enable_second_bank_reg[EN1_WAKEPIN],
                    irq_enable_second_bank_reg[EN1_SERDONE],
                    irq_enable_second_bank_reg[EN1_RFEVENT],
                    irq_enable_second_bank_reg[EN1_RFREADY],
                    irq_enable_first_bank_reg[EN0_TIMER2],
                    irq_enable_first_bank_reg[EN0_SERIAL],
                    irq_enable_first_bank_reg[EN0_TIMER1],
                    irq_enable_first_bank_reg[EN0_POWER],
                    irq_enable_first_bank_reg[EN0_TIMER0],
                    irq_enable_first_bank_reg[EN0_PIN]};
  logic reload_gate;
  // Reload alone may be masked by its own bit while overflow stays on
  assign reload_gate = request_flag_reg[RF_T2OVF] |
                       (request_flag_reg[RF_RELOAD] & irq_enable_second_bank_reg[EN1_RELOAD]);
  logic [NUM_LINES-1:0] line_req_g;
  assign line_req_g = {line_req[11:6], reload_gate, line_req[4:0]};
  assign arb_bus.pending = global_en ? (line_req_g & line_en) : '0;
  assign arb_bus.active_levels = active_reg;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_level
      assign arb_bus.level[gi] = {irq_priority_high_bits_reg[GROUP_OF[gi]],
                                  irq_priority_low_bits_reg[GROUP_OF[gi]]};
    end
  endgenerate
  gpic_arbiter u_arb (
    .bus (arb_bus.arb)
  );

  // ==================================================
  // Core handshake and service tracking
  logic [3:0] ack_level_bit;
  logic [3:0] ret_level_bit;
  always_comb begin
    ack_level_bit = '0;
    ret_level_bit = '0;
    ack_level_bit[level_reg] = irq_request & irq_ack;
    // Return always ends the innermost, highest running routine
    for (int l = 0; l < 4; l++) begin
      if (active_reg[l]) begin
        ret_level_bit = '0;
        ret_level_bit[l] = irq_return;
      end
    end
  end
  assign active_next = (active_reg & ~ret_level_bit) | ack_level_bit;
  // Clear follows the vector that was acknowledged, not the new winner
  always_comb begin
    svc_clr = '0;
    if (irq_request && irq_ack) begin
      unique case (vector_reg)
        VECTORS[7]:  svc_clr[RF_RFEVENT] = 1'b1;
        VECTORS[8]:  svc_clr[RF_SERDONE] = 1'b1;
        VECTORS[9]:  svc_clr[RF_WAKEPIN] = 1'b1;
        VECTORS[10]: svc_clr[RF_MISC]    = 1'b1;
        VECTORS[11]: svc_clr[RF_TICK]    = 1'b1;
        default:     svc_clr = '0;
      endcase
    end
  end

  // ==================================================
  // Register read mux
  // Reads have no side effects; flags change by hardware events, write or service only
  logic [7:0] rdata_next;
  always_comb begin
    unique case (reg_addr)
      ADDR_PIN_ROUTE:  rdata_next = pin_route_and_serial_done_enable_reg;
      ADDR_ENABLE_1ST: rdata_next = irq_enable_first_bank_reg;
      ADDR_PRIO_LOW:   rdata_next = irq_priority_low_bits_reg;
      ADDR_ENABLE_2ND: rdata_next = irq_enable_second_bank_reg;
      ADDR_PRIO_HIGH:  rdata_next = irq_priority_high_bits_reg;
      ADDR_REQ_FLAGS:  rdata_next = request_flag_reg;
      default:         rdata_next = 8'h00;
    endcase
  end

  // ==================================================
  // Configuration registers; unused bits are dropped on write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_route_and_serial_done_enable_reg <= RST_PIN_ROUTE;
      irq_enable_first_bank_reg  <= RST_ZERO;
      irq_enable_second_bank_reg <= RST_ZERO;
      irq_priority_low_bits_reg  <= RST_ZERO;
      irq_priority_high_bits_reg <= RST_ZERO;
    end else begin
      if (we_pin_route) begin
        pin_route_and_serial_done_enable_reg <= reg_wdata & PR_USED;
      end
      if (we_enable_1st) begin
        irq_enable_first_bank_reg <= reg_wdata & EN0_USED;
      end
      if (we_enable_2nd) begin
        irq_enable_second_bank_reg <= reg_wdata & EN1_USED;
      end
      if (we_prio_low) begin
        irq_priority_low_bits_reg <= reg_wdata & PRIO_USED;
      end
      if (we_prio_high) begin
        irq_priority_high_bits_reg <= reg_wdata & PRIO_USED;
      end
    end
  end

  // ==================================================
  // Flags, service state and the offer to the core
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      request_flag_reg <= RST_ZERO;
      active_reg       <= '0;
      prev_in_reg      <= '0;
      vector_reg       <= '0;
      level_reg        <= '0;
      irq_request      <= 1'b0;
      reg_rdata        <= 8'h00;
    end else begin
      request_flag_reg <= request_flag_next;
      active_reg       <= active_next;
      prev_in_reg      <= raw_in;
      // Offer is refreshed while not being acknowledged
      irq_request      <= arb_bus.found & ~(irq_request & irq_ack);
      vector_reg       <= VECTORS[arb_bus.line];
      level_reg        <= arb_bus.line_level;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  assign irq_vector        = vector_reg;
  assign irq_level         = level_reg;
  assign irq_active_levels = active_reg;
endmodule : gpic_controller

// ---- tb/gpic_controller_sva.sv ----
// ======================================
// Shadows of the first enable bank and the priority registers
module gpic_controller_sva
  import gpic_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0]  irq_level,
  input wire logic        irq_ack,
  input wire logic        irq_return,
  input wire logic [3:0]  irq_active_levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] e0_reg, pl_reg, ph_reg;
  logic [3:0] act_popped;
  logic [2:0] grp;
  // Vectors step by 8 in both banks, so bits 5:3 name the group
  assign grp = irq_vector[5:3];
  assign act_popped = irq_active_levels[3] ? irq_active_levels & 4'h7 :
                      irq_active_levels[2] ? irq_active_levels & 4'h3 :
                      irq_active_levels[1] ? irq_active_levels & 4'h1 : 4'h0;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      e0_reg <= 8'h00;
      pl_reg <= 8'h00;
      ph_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_ENABLE_1ST) e0_reg <= reg_wdata & 8'hBF;
      if (reg_addr == ADDR_PRIO_LOW) pl_reg <= reg_wdata & 8'h3F;
      if (reg_addr == ADDR_PRIO_HIGH) ph_reg <= reg_wdata & 8'h3F;
    end
  end
  // ======================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_global_off; (!e0_reg[7]) [*2] |-> !irq_request; endproperty
  a_global_off: assert property (p_global_off) else $error("offer while disabled");
  property p_ack_drop; irq_ack && irq_request |=> !irq_request; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("offer kept after ack");
  property p_ack_level; irq_ack && irq_request |=> irq_active_levels[$past(irq_level)]; endproperty
  a_ack_level: assert property (p_ack_level) else $error("level not marked running");
  property p_no_preempt; irq_request |-> (irq_active_levels >> irq_level) == 4'h0; endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("offer not above running");
  property p_vector_set;
    irq_request |-> irq_vector[15:6] == 10'h001 && irq_vector[2:0] == 3'h3 && grp < 3'h6
      || irq_vector[15:6] == 10'h000 && irq_vector[2:0] == 3'h3 && grp < 3'h6;
  endproperty
  a_vector_set: assert property (p_vector_set) else $error("vector outside table");
  property p_level;
    irq_request && !$past(reg_wr) && !$past(reg_wr, 2) |-> irq_level == {ph_reg[grp], pl_reg[grp]};
  endproperty
  a_level: assert property (p_level) else $error("level not from group bits");
  property p_prio_read; reg_rd && reg_addr == ADDR_PRIO_LOW |=> reg_rdata == $past(pl_reg); endproperty
  a_prio_read: assert property (p_prio_read) else $error("priority readback wrong");
  property p_return; irq_return && !irq_ack |=> irq_active_levels == $past(act_popped); endproperty
  a_return: assert property (p_return) else $error("return popped wrong level");
  c_take: cover property (irq_ack && irq_request);
  c_nested: cover property (irq_active_levels == 4'hA);
  c_return: cover property (irq_return && irq_active_levels == 4'hA);
endmodule // gpic_controller_sva

bind gpic_controller gpic_controller_sva u_sva (.*);

// ---- tb/gpic_core_model.sv ----
// ======================================
// Core side: takes offers, ends routines on command
module gpic_core_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        irq_request,
  input  wire logic [15:0] irq_vector,
  input  wire logic        ack_en,
  input  wire logic [1:0]  slow,
  input  wire logic        ret_req,
  output logic             irq_ack,
  output logic             irq_return,
  output logic      [15:0] last_vec,
  output logic      [7:0]  n_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_reg;
  logic       take;
  // Ack lasts one cycle and only answers a standing offer
  assign take = irq_request && !irq_ack && ack_en && wait_reg >= slow;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_ack    <= 1'b0;
      irq_return <= 1'b0;
      wait_reg   <= 2'h0;
      last_vec   <= 16'h0000;
      n_taken    <= 8'h00;
    end else begin
      irq_ack    <= take;
      irq_return <= ret_req;
      wait_reg   <= (irq_request && !irq_ack && !take) ? wait_reg + 2'h1 : 2'h0;
      // Vector is taken at the edge where the ack meets the offer
      if (irq_ack && irq_request) begin
        last_vec <= irq_vector;
        n_taken  <= n_taken + 8'h01;
      end
    end
  end
endmodule // gpic_core_model

// ---- tb/test_grouped_priority_irq_controller.sv ----
module test_grouped_priority_irq_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import gpic_pkg::*;
  // ======================================
  // Stimulus and source table
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ack_en = 1'b1;
  logic        ret_req = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [17:0] req = '0;
  logic [3:0]  wk = 4'h0;
  logic [1:0]  slow = 2'h0;
  logic [7:0]  reg_rdata, n_taken;
  logic        irq_request, irq_ack, irq_return;
  logic [1:0]  irq_level;
  logic [3:0]  irq_active_levels;
  logic [15:0] irq_vector, last_vec;
  int          n_errors = 0;
  int          check_count = 0;
  logic [15:0] t_vec [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
                              16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B};
  logic [7:0]  t_e0 [12] = '{8'h81, 8'h82, 8'h84, 8'h88, 8'h90, 8'hA0,
                             8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80};
  logic [7:0]  t_e1 [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80,
                             8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
  int          t_wk [12] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 2, 4, 8};
  int          t_bit [12] = '{17, 0, 6, 1, 5, 3, 7, 8, 11, 12, 15, 16};
  logic [7:0]  t_addr [5] = '{ADDR_PIN_ROUTE, ADDR_ENABLE_1ST, ADDR_PRIO_LOW,
                              ADDR_ENABLE_2ND, ADDR_PRIO_HIGH};
  logic [7:0]  t_mask [5] = '{8'h3F, 8'hBF, 8'h3F, 8'hBF, 8'h3F};

  always #20 clock = ~clock;

  gpic_controller u_dut (
    .*,
    .general_pin_input({2'h3, ~req[17]}),
    .timer0_overflow_req(req[0]), .timer1_overflow_req(req[1]),
    .timer2_overflow_req(req[2]), .timer2_reload_req(req[3]),
    .serial_receive_req(req[4]), .serial_transmit_req(req[5]),
    .power_failure_req(~req[6]), .radio_port_ready_req(req[7]),
    .radio_event_req(req[8]), .spi_master_done_req(req[9]),
    .spi_slave_done_req(req[10]), .two_wire_done_req(req[11]),
    .wake_on_pin_req(req[12]), .crystal_started_event(req[13]),
    .converter_ready_event(req[14]), .random_ready_event(req[15]),
    .tick_req(req[16]), .wakeup_enable(wk));
  gpic_core_model u_core (.*);

  // ======================================
  // Bus cycles and comparisons
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic note(input logic bad, input string what);
    check_count++;
    if (bad) begin
      n_errors++;
      $display("[ERR] %0t %s mismatch", $time, what);
    end
  endtask
  task automatic cmp_reg(input logic [7:0] g, e);
    note(g !== e, "register");
  endtask
  task automatic cmp_vec(input logic [15:0] g, e);
    note(g !== e, "vector");
  endtask
  task automatic cmp_flag(input logic g, e);
    note(g !== e, "taken");
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cmp_reg(reg_rdata, e);
    cyc(1);
  endtask
  task automatic wait_take(input logic exp);
    logic [7:0] n0;
    n0 = n_taken;
    for (int k = 0; k < 30 && n_taken === n0; k++) cyc(1);
    cmp_flag(n_taken !== n0, exp);
  endtask
  task automatic ret_pulse();
    ret_req = 1'b1;
    cyc(1);
    ret_req = 1'b0;
    cyc(2);
  endtask
  // Flags left standing after service: only the non-clearing lines
  function automatic logic [7:0] exp_flags(input int i, input int b);
    if (i == 5) return (b == 2) ? 8'h40 : 8'h80;
    if (i == 6) return 8'h01;
    return 8'h00;
  endfunction
  // Either-edge sources flag again on the way down, so flags are wiped last
  task automatic run_case(input int i, input logic [7:0] g, input int wm, input logic exp);
    int b;
    b = t_bit[i];
    if (i == 4 || i == 5) b = b - int'($urandom_range(0, 1));
    if (i == 8 || i == 10) b = b - int'($urandom_range(0, 2));
    wr(ADDR_ENABLE_1ST, 8'h00);
    wr(ADDR_PIN_ROUTE, 8'h0F);
    wr(ADDR_ENABLE_2ND, t_e1[i]);
    wk = 4'(t_wk[i] & wm);
    slow = 2'($urandom_range(0, 3));
    req[b] = 1'b1;
    wr(ADDR_ENABLE_1ST, t_e0[i] & g);
    wait_take(exp);
    if (exp) cmp_vec(last_vec, t_vec[i]);
    if (exp) rd_chk(ADDR_REQ_FLAGS, exp_flags(i, b));
    wr(ADDR_ENABLE_1ST, 8'h00);
    req = '0;
    cyc(3);
    wr(ADDR_REQ_FLAGS, 8'h00);
    if (exp) ret_pulse();
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run needs about 1100 cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    close_out();
  end

  initial begin
    int j;
    void'($urandom(91199));
    cyc(2);
    rst = 1'b0;
    for (j = 0; j < 5; j++) rd_chk(t_addr[j], j == 0 ? 8'h01 : 8'h00);
    rd_chk(8'h55, 8'h00);
    repeat (20) begin
      j = $urandom_range(0, 4);
      reg_wdata = 8'($urandom);
      wr(t_addr[j], reg_wdata);
      rd_chk(t_addr[j], reg_wdata & t_mask[j]);
    end
    wr(ADDR_PRIO_LOW, 8'h00);
    wr(ADDR_PRIO_HIGH, 8'h00);
    for (int i = 0; i < 12; i++) begin
      run_case(i, 8'h7F, 15, 1'b0);
      run_case(i, 8'hFF, 15, 1'b1);
    end
    run_case(11, 8'hFF, 0, 1'b0);
    wr(ADDR_ENABLE_2ND, 8'h00);
    wr(ADDR_PRIO_LOW, 8'h1A);
    wr(ADDR_PRIO_HIGH, 8'h08);
    wr(ADDR_ENABLE_1ST, 8'h9A);
    req = 18'h00001;
    wait_take(1'b1);
    cmp_vec(last_vec, 16'h000B);
    req = 18'h00002;
    wait_take(1'b1);
    cmp_vec(last_vec, 16'h001B);
    req = 18'h00010;
    wait_take(1'b0);
    ret_pulse();
    wait_take(1'b0);
    ret_pulse();
    wait_take(1'b1);
    cmp_vec(last_vec, 16'h0023);
    req = '0;
    ret_pulse();
    ack_en = 1'b0;
    wr(ADDR_PRIO_LOW, 8'h00);
    wr(ADDR_PRIO_HIGH, 8'h00);
    req = 18'h00003;
    cyc(4);
    cmp_flag(irq_request, 1'b1);
    cmp_vec(irq_vector, 16'h000B);
    wr(ADDR_PRIO_HIGH, 8'h08);
    cyc(4);
    cmp_vec(irq_vector, 16'h001B);
    cmp_reg({6'h00, irq_level}, 8'h02);
    req = '0;
    close_out();
  end
endmodule // test_grouped_priority_irq_controller
